/* File: ddct_params.svh */
// Offsets, field positions, reset values and timing figures of the dual decade counter/timer.
`ifndef DDCT_PARAMS_SVH
`define DDCT_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define DDCT_OFS_CTRL 8'h00
`define DDCT_OFS_PRESET 8'h04
`define DDCT_OFS_DWELL 8'h08
`define DDCT_OFS_CMD 8'h0C
`define DDCT_OFS_STATUS 8'h10
`define DDCT_OFS_COUNT_A 8'h14
`define DDCT_OFS_COUNT_B 8'h18

// ==========================================================
// Control register fields
`define DDCT_CTRL_MODE 1:0
`define DDCT_CTRL_RTGT 3:2
`define DDCT_CTRL_DISP_B 4
`define DDCT_CTRL_PSEL 6:5
`define DDCT_CTRL_BSRC 8:7
`define DDCT_CTRL_MASTER 9
`define DDCT_CTRL_A_TO_B 10
`define DDCT_CTRL_B_TO_A 11
`define DDCT_CTRL_RST 12'h00C

// Preset register fields: digit and power for each counter.
`define DDCT_PRE_MA 3:0
`define DDCT_PRE_NA 6:4
`define DDCT_PRE_MB 11:8
`define DDCT_PRE_NB 14:12
`define DDCT_PRE_RST 15'h0000

// Command register bits, write only.
`define DDCT_CMD_START 0
`define DDCT_CMD_STOP 1
`define DDCT_CMD_RESET 2

// ==========================================================
// Counter sizes and timing
`define DDCT_DIGITS_A 7
`define DDCT_DIGITS_B 6
`define DDCT_CLK_MHZ 200
`define DDCT_OVF_PULSE_NS 2000
`define DDCT_OVF_PULSE_CYC ((`DDCT_OVF_PULSE_NS * `DDCT_CLK_MHZ) / 1000)
`define DDCT_TENTH_MS 100
`define DDCT_TENTH_CYC (`DDCT_TENTH_MS * `DDCT_CLK_MHZ * 1000)
`define DDCT_DWELL_MIN 7'h03
`define DDCT_DWELL_MAX 7'h64
`define DDCT_DWELL_RST 7'h0A
`define DDCT_LINE_HZ 60
`define DDCT_SEC_PER_MIN 60

`endif

/* File: ddct_pkg.sv */
// Types shared by the dual decade counter/timer.
package ddct_pkg;

  // ==========================================================
  // Operating modes and control states
  typedef enum logic [1:0] {
    DDCT_SINGLE,
    DDCT_RECYCLE,
    DDCT_TEST
  } ddct_mode_type;

  typedef enum logic [1:0] {
    DDCT_RUN,
    DDCT_HALT,
    DDCT_DWELL
  } ddct_state_type;

endpackage

/* File: ddct_counter_timer.sv */
// Dual decade counter/timer: two BCD counters, presets, time base and run control.
`timescale 1ns/1ps
`default_nettype none
`include "ddct_params.svh"

// How it works
// - Counter A is seven cascaded BCD decades, maximum 9999999.
// - Counter B has six decades, input from pulses or time base.
// - As timer, B advances once per 0.1 s or 0.1 min tick.
// - Both counters take external pulses at up to 20 MHz together.
// - Either overflow can feed the other counter, forming thirteen decades.
// - Auto-repeat dwells 0.3 to 10 s in stopped state before resuming.
// - Without printer, mode is single-pass, self-check or auto-repeat.
// - Single-pass leaves counting at a preset and counts no further.
// - Auto-repeat stops at each preset and restarts by itself.
// - Stop, start, preset, system gate and system preset act on both counters.
// - Reset requests hit counter A, counter B or both as selected.
// - Each counter has its own gate input enabling its counting.
// - Per-counter preset compare works without clearing the counter.
// - Overflow flag sets at first overflow, stays until counter reset.
// - One output pulse on every wrap of each counter.
// - Interval output high while a counter may count.
// - Display shows counter A or B as selected, seven digits.
// - Unit acts as system controller or follower; printer sequences repeats.
// - Readout selects counter A, counter B or both.
// - Preset is digit 1..9 times ten to power; digit zero disables.
// - After dwell, selected counters reset and a new interval begins.
// - Manual reset works only while not counting.
// - After single-pass preset stop, wait for a restart command.
module ddct_counter_timer
  import ddct_pkg::*;
#(
  parameter int LINE_HZ = `DDCT_LINE_HZ,
  parameter int TENTH_CYC = `DDCT_TENTH_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic pulse_a,
  input wire logic pulse_b,
  input wire logic gate_a,
  input wire logic gate_b,
  input wire logic ext_reset,
  input wire logic line_in,
  input wire logic sys_gate_i,
  output logic sys_gate_o,
  output logic sys_gate_oe_n,
  input wire logic sys_reset_i,
  output logic sys_reset_o,
  input wire logic sys_preset_i,
  output logic sys_preset_o,
  input wire logic print_on,
  input wire logic print_recycle,
  output logic readout_a,
  output logic readout_b,
  output logic ovf_pulse_a,
  output logic ovf_pulse_b,
  output logic ovf_flag_a,
  output logic ovf_flag_b,
  output logic interval,
  output logic gate_on_a,
  output logic gate_on_b,
  output logic [27:0] disp_digits,
  output logic disp_is_b
);

  localparam int NSYNC = 11;
  localparam int TB_DIV = LINE_HZ / 10;

  // ==========================================================
  // BCD helpers
  // Increment the low nd decades; bit 28 is the carry out of the top decade.
  function automatic logic [28:0] bcd_inc(input logic [27:0] v, input int nd);
    logic [28:0] r;
    logic c;
    r = 29'h0;
    c = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i < nd) begin
        if (c && v[4*i+:4] == 4'h9) begin
          r[4*i+:4] = 4'h0;
        end else begin
          r[4*i+:4] = v[4*i+:4] + {3'h0, c};
          c = 1'b0;
        end
      end
    end
    r[28] = c;
    return r;
  endfunction

  // True when v equals m times ten to n in its low decades up to n.
  function automatic logic preset_hit(input logic [27:0] v, input logic [3:0] m,
                                      input logic [2:0] n, input int nd);
    logic h;
    h = (m != 4'h0) && (m <= 4'h9) && (int'(n) < nd);
    for (int i = 0; i < 7; i++) begin
      if (i < int'(n) && v[4*i+:4] != 4'h0) begin
        h = 1'b0;
      end
      if (i == int'(n) && v[4*i+:4] != m) begin
        h = 1'b0;
      end
    end
    return h;
  endfunction

  // ==========================================================
  // Pin synchronisers
  // Stage one feeds only stage two; stage three exists for edge detection.
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  assign pin_raw = {print_recycle, print_on, sys_preset_i, sys_reset_i, sys_gate_i,
                    line_in, ext_reset, gate_b, gate_a, pulse_b, pulse_a};

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // At 200 MHz, 20 MHz pulses still give ten samples per period.
  logic [NSYNC-1:0] rise;
  assign rise = s2_r & ~s3_r;

  // ==========================================================
  // Registers
  logic [11:0] ctrl_r;
  logic [14:0] preset_r;
  logic [6:0] dwell_r;
  logic [27:0] cnt_a_r;
  logic [27:0] cnt_b_r;
  ddct_state_type state_r;
  logic cmd_start;
  logic cmd_stop;
  logic cmd_reset;
  logic cmd_wr;

  assign cmd_wr = wr && addr == `DDCT_OFS_CMD;
  assign cmd_start = cmd_wr && wdata[`DDCT_CMD_START];
  assign cmd_stop = cmd_wr && wdata[`DDCT_CMD_STOP];
  assign cmd_reset = cmd_wr && wdata[`DDCT_CMD_RESET];

  // Configuration writes; dwell is clamped to its legal range.
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_r <= `DDCT_CTRL_RST;
      preset_r <= `DDCT_PRE_RST;
      dwell_r <= `DDCT_DWELL_RST;
    end else if (wr) begin
      if (addr == `DDCT_OFS_CTRL) begin
        ctrl_r <= wdata[11:0];
      end
      if (addr == `DDCT_OFS_PRESET) begin
        preset_r <= wdata[14:0];
      end
      if (addr == `DDCT_OFS_DWELL) begin
        if (wdata[6:0] < `DDCT_DWELL_MIN) begin
          dwell_r <= `DDCT_DWELL_MIN;
        end else if (wdata[31:7] != 25'h0 || wdata[6:0] > `DDCT_DWELL_MAX) begin
          dwell_r <= `DDCT_DWELL_MAX;
        end else begin
          dwell_r <= wdata[6:0];
        end
      end
    end
  end

  // Read data stands in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 32'h0;
    end else if (rd) begin
      case (addr)
        `DDCT_OFS_CTRL: rdata <= {20'h0, ctrl_r};
        `DDCT_OFS_PRESET: rdata <= {17'h0, preset_r};
        `DDCT_OFS_DWELL: rdata <= {25'h0, dwell_r};
        `DDCT_OFS_STATUS: rdata <= {27'h0, interval, ovf_flag_b, ovf_flag_a, state_r};
        `DDCT_OFS_COUNT_A: rdata <= {4'h0, cnt_a_r};
        `DDCT_OFS_COUNT_B: rdata <= {4'h0, cnt_b_r};
        default: rdata <= 32'h0;
      endcase
    end else begin
      rdata <= 32'h0;
    end
  end

  // ==========================================================
  // Mode and system roles
  logic master;
  ddct_mode_type mode;
  assign master = ctrl_r[`DDCT_CTRL_MASTER];

  // mode selection
  // A connected printer overrides the local switch.
  always_comb begin
    if (s2_r[9]) begin
      mode = s2_r[10] ? DDCT_RECYCLE : DDCT_SINGLE;
    end else begin
      case (ctrl_r[`DDCT_CTRL_MODE])
        2'h1: mode = DDCT_RECYCLE;
        2'h2: mode = DDCT_TEST;
        default: mode = DDCT_SINGLE;
      endcase
    end
  end

  // ==========================================================
  // Time base from the line frequency
  logic [7:0] tb_div_r;
  logic [5:0] tb_min_r;
  logic tick_s_r;
  logic tick_m_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      tb_div_r <= 8'h00;
      tb_min_r <= 6'h00;
      tick_s_r <= 1'b0;
      tick_m_r <= 1'b0;
    end else begin
      tick_s_r <= 1'b0;
      tick_m_r <= 1'b0;
      if (rise[5]) begin
        if (tb_div_r == 8'(TB_DIV - 1)) begin
          tb_div_r <= 8'h00;
          tick_s_r <= 1'b1;
          if (tb_min_r == 6'(`DDCT_SEC_PER_MIN - 1)) begin
            tb_min_r <= 6'h00;
            tick_m_r <= 1'b1;
          end else begin
            tb_min_r <= tb_min_r + 6'h01;
          end
        end else begin
          tb_div_r <= tb_div_r + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Count sources, presets and resets
  logic running;
  logic ovf_evt_a_r;
  logic ovf_evt_b_r;
  logic src_a;
  logic src_b;
  logic inc_a;
  logic inc_b;
  logic [28:0] nxt_a;
  logic [28:0] nxt_b;
  logic hit_a;
  logic hit_b;
  logic preset_evt;
  logic reset_req;
  logic clr_a;
  logic clr_b;
  logic dwell_done;

  // follower obeys the shared gate line
  assign running = state_r == DDCT_RUN && (master || s2_r[6]);

  // overflow cascading
  // Test mode feeds the line fundamental into counter A.
  assign src_a = mode == DDCT_TEST ? rise[5] : ctrl_r[`DDCT_CTRL_B_TO_A] ? ovf_evt_b_r : rise[0];

  always_comb begin
    case (ctrl_r[`DDCT_CTRL_BSRC])
      2'h1: src_b = tick_s_r;
      2'h2: src_b = tick_m_r;
      default: src_b = ctrl_r[`DDCT_CTRL_A_TO_B] ? ovf_evt_a_r : rise[1];
    endcase
  end

  assign inc_a = running && s2_r[2] && src_a;
  assign inc_b = running && s2_r[3] && src_b;
  assign nxt_a = bcd_inc(cnt_a_r, `DDCT_DIGITS_A);
  assign nxt_b = bcd_inc(cnt_b_r, `DDCT_DIGITS_B);

  // compare on the new value only
  assign hit_a = inc_a && preset_hit(nxt_a[27:0], preset_r[`DDCT_PRE_MA],
                                     preset_r[`DDCT_PRE_NA], `DDCT_DIGITS_A);
  assign hit_b = inc_b && preset_hit(nxt_b[27:0], preset_r[`DDCT_PRE_MB],
                                     preset_r[`DDCT_PRE_NB], `DDCT_DIGITS_B);

  assign preset_evt = hit_a || hit_b || (!master && rise[8]);

  assign reset_req = (cmd_reset && state_r != DDCT_RUN) || rise[4] ||
                     (!master && rise[7]) || dwell_done;

  assign clr_a = reset_req && ctrl_r[2];
  assign clr_b = reset_req && ctrl_r[3];

  // ==========================================================
  // Decade counters
  // seven decades
  always_ff @(posedge clock) begin
    if (rst || clr_a) begin
      cnt_a_r <= 28'h0;
    end else if (inc_a) begin
      cnt_a_r <= nxt_a[27:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || clr_b) begin
      cnt_b_r <= 28'h0;
    end else if (inc_b) begin
      cnt_b_r <= nxt_b[27:0];
    end
  end

  // ==========================================================
  // Overflow flags and pulses
  logic [8:0] ovf_cnt_a_r;
  logic [8:0] ovf_cnt_b_r;

  // sticky flag, a new overflow wins over a clear
  always_ff @(posedge clock) begin
    if (rst) begin
      ovf_evt_a_r <= 1'b0;
      ovf_evt_b_r <= 1'b0;
      ovf_flag_a <= 1'b0;
      ovf_flag_b <= 1'b0;
    end else begin
      ovf_evt_a_r <= inc_a && nxt_a[28];
      ovf_evt_b_r <= inc_b && nxt_b[28];
      if (ovf_evt_a_r) begin
        ovf_flag_a <= 1'b1;
      end else if (clr_a) begin
        ovf_flag_a <= 1'b0;
      end
      if (ovf_evt_b_r) begin
        ovf_flag_b <= 1'b1;
      end else if (clr_b) begin
        ovf_flag_b <= 1'b0;
      end
    end
  end

  // stretched overflow pulse
  // Wraps closer than the pulse width merge into one longer pulse.
  always_ff @(posedge clock) begin
    if (rst) begin
      ovf_cnt_a_r <= 9'h000;
      ovf_cnt_b_r <= 9'h000;
      ovf_pulse_a <= 1'b0;
      ovf_pulse_b <= 1'b0;
    end else begin
      if (ovf_evt_a_r) begin
        ovf_cnt_a_r <= 9'(`DDCT_OVF_PULSE_CYC - 1);
      end else if (ovf_cnt_a_r != 9'h000) begin
        ovf_cnt_a_r <= ovf_cnt_a_r - 9'h001;
      end
      if (ovf_evt_b_r) begin
        ovf_cnt_b_r <= 9'(`DDCT_OVF_PULSE_CYC - 1);
      end else if (ovf_cnt_b_r != 9'h000) begin
        ovf_cnt_b_r <= ovf_cnt_b_r - 9'h001;
      end
      ovf_pulse_a <= ovf_evt_a_r || ovf_cnt_a_r > 9'h001;
      ovf_pulse_b <= ovf_evt_b_r || ovf_cnt_b_r > 9'h001;
    end
  end

  // ==========================================================
  // Run control
  logic [24:0] tenth_r;
  logic [6:0] dwell_cnt_r;
  logic tenth_end;

  assign tenth_end = tenth_r == 25'(TENTH_CYC - 1);
  assign dwell_done = state_r == DDCT_DWELL && tenth_end && dwell_cnt_r == dwell_r;

  // Power-on leaves the unit counting; stop and start act on both counters.
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= DDCT_RUN;
    end else begin
      case (state_r)
        DDCT_RUN: begin
          if (cmd_stop) begin
            state_r <= DDCT_HALT;
          end else if (preset_evt) begin
            if (mode != DDCT_SINGLE && !s2_r[9]) begin
              state_r <= DDCT_DWELL;
            end else begin
              state_r <= DDCT_HALT;
            end
          end
        end
        DDCT_HALT: begin
          if (cmd_start) begin
            state_r <= DDCT_RUN;
          end
        end
        DDCT_DWELL: begin
          if (cmd_stop) begin
            state_r <= DDCT_HALT;
          end else if (dwell_done || cmd_start) begin
            state_r <= DDCT_RUN;
          end
        end
        default: state_r <= DDCT_HALT;
      endcase
    end
  end

  // dwell timing in tenths of a second
  always_ff @(posedge clock) begin
    if (rst || state_r != DDCT_DWELL) begin
      tenth_r <= 25'h0;
      dwell_cnt_r <= 7'h01;
    end else if (tenth_end) begin
      tenth_r <= 25'h0;
      dwell_cnt_r <= dwell_cnt_r + 7'h01;
    end else begin
      tenth_r <= tenth_r + 25'h1;
    end
  end

  // ==========================================================
  // Outputs
  // controller drives shared lines; open drain pulls gate low.
  always_ff @(posedge clock) begin
    if (rst) begin
      sys_gate_o <= 1'b0;
      sys_gate_oe_n <= 1'b1;
      sys_reset_o <= 1'b0;
      sys_preset_o <= 1'b0;
      interval <= 1'b0;
      gate_on_a <= 1'b0;
      gate_on_b <= 1'b0;
      disp_digits <= 28'h0;
      disp_is_b <= 1'b0;
      readout_a <= 1'b0;
      readout_b <= 1'b0;
    end else begin
      sys_gate_o <= 1'b0;
      sys_gate_oe_n <= !(master && state_r != DDCT_RUN);
      sys_reset_o <= master && reset_req;
      sys_preset_o <= master && (hit_a || hit_b);
      interval <= running;
      gate_on_a <= running && s2_r[2];
      gate_on_b <= running && s2_r[3];
      disp_is_b <= ctrl_r[`DDCT_CTRL_DISP_B];
      disp_digits <= ctrl_r[`DDCT_CTRL_DISP_B] ? cnt_b_r : cnt_a_r;
      readout_a <= ctrl_r[5];
      readout_b <= ctrl_r[6];
    end
  end

endmodule
`default_nettype wire

/* File: ddct_counter_timer_properties.sv */
// Concurrent checks on the ports of the dual decade counter/timer.
`timescale 1ns/1ps
`default_nettype none
module ddct_counter_timer_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic sys_gate_o,
  input wire logic sys_gate_oe_n,
  input wire logic sys_reset_o,
  input wire logic sys_preset_o,
  input wire logic ovf_pulse_a,
  input wire logic ovf_flag_a,
  input wire logic interval,
  input wire logic gate_on_a,
  input wire logic gate_on_b,
  input wire logic [27:0] disp_digits,
  input wire logic disp_is_b
);
  logic bcd_ok;

  // ==========================================================
  // Helper logic
  // Every shown digit must stay a legal decimal value.
  always_comb begin
    bcd_ok = 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (disp_digits[4*i+:4] > 4'h9) begin
        bcd_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Assertions
  a_intv_gates: assert property (
    (gate_on_a || gate_on_b) |-> interval) else $error("gate lamp lit outside interval");
  a_digits_bcd: assert property (
    bcd_ok) else $error("display digit above nine");
  a_disp_b_top: assert property (
    disp_is_b |-> disp_digits[27:24] == 4'h0) else $error("top digit set for counter B");
  a_ovf_flag_set: assert property (
    $rose(ovf_pulse_a) |-> ovf_flag_a) else $error("overflow pulse without flag");
  a_ovf_width: assert property (
    $rose(ovf_pulse_a) |-> ovf_pulse_a [*8]) else $error("overflow pulse too short");
  a_preset_once: assert property (
    sys_preset_o |=> !sys_preset_o) else $error("preset line held high");
  a_reset_once: assert property (
    sys_reset_o |=> !sys_reset_o) else $error("reset line held high");
  a_preset_halts: assert property (
    $rose(sys_preset_o) |-> ##[0:3] !interval) else $error("counting kept after preset");
  a_oe_idle_only: assert property (
    !sys_gate_oe_n |-> !interval && !sys_gate_o) else $error("gate line pulled while running");

  // Main scenarios reached.
  c_preset: cover property ($rose(sys_preset_o));
  c_reset: cover property ($rose(sys_reset_o));
  c_both_gated: cover property (gate_on_a && gate_on_b);
endmodule

bind ddct_counter_timer ddct_counter_timer_properties u_ddct_counter_timer_properties (.*);
`default_nettype wire

/* File: ddct_far_side.sv */
// Far-side model: two pulse sources, a mains stand-in and an absent printer.
`timescale 1ns/1ps
`default_nettype none
module ddct_far_side (
  input wire logic clock,
  output logic pulse_a,
  output logic pulse_b,
  output logic line_in,
  output logic print_on,
  output logic print_recycle
);
  logic [3:0] line_cnt = 4'h0;

  // No printout controller is attached, so the mode comes from the registers.
  // printer absent
  initial begin
    pulse_a = 1'b0;
    pulse_b = 1'b0;
    line_in = 1'b0;
    print_on = 1'b0;
    print_recycle = 1'b0;
  end

  // Mains stand-in of twenty clocks period; far faster than real mains to keep runs short.
  // time base
  always @(posedge clock) begin
    line_cnt <= (line_cnt == 4'h9) ? 4'h0 : line_cnt + 4'h1;
    if (line_cnt == 4'h9) begin
      line_in <= ~line_in;
    end
  end

  // Pulses at 20 MHz, five clocks high and five low, on either or both channels.
  // full rate
  task automatic burst(input logic [1:0] ch, input int n);
    @(posedge clock);
    repeat (n) begin
      pulse_a <= ch[0];
      pulse_b <= ch[1];
      repeat (5) @(posedge clock);
      pulse_a <= 1'b0;
      pulse_b <= 1'b0;
      repeat (5) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

/* File: ddct_counter_timer_tb.sv */
// Self-checking bench for the dual decade counter/timer.
`timescale 1ns/1ps
`default_nettype none
`include "ddct_params.svh"
module ddct_counter_timer_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic gate_a = 1'b1;
  logic gate_b = 1'b1;
  logic ext_reset = 1'b0;
  logic sys_reset_i = 1'b0;
  logic sys_preset_i = 1'b0;
  logic [31:0] rdata;
  logic pulse_a, pulse_b, line_in, print_on, print_recycle, sys_gate_o, sys_gate_oe_n;
  logic sys_reset_o, sys_preset_o, readout_a, readout_b, ovf_pulse_a, ovf_pulse_b;
  logic ovf_flag_a, ovf_flag_b, interval, gate_on_a, gate_on_b, disp_is_b;
  logic [27:0] disp_digits;
  wire logic sys_gate_i;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  // The shared gate line is open drain with a pull-up.
  assign sys_gate_i = sys_gate_oe_n ? 1'b1 : sys_gate_o;

  // 200 MHz clock.
  always #2.5 clock = ~clock;

  // Short tenth-second and mains divide keep the dwell and timer runs brief.
  ddct_counter_timer #(.LINE_HZ(20), .TENTH_CYC(20)) u_ddct_counter_timer (.*);
  ddct_far_side u_ddct_far_side (.*);

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(`DDCT_OFS_CTRL, 32'hC);
    rd_chk(`DDCT_OFS_PRESET, 32'h0);
    rd_chk(`DDCT_OFS_DWELL, 32'hA);
    rd_chk(`DDCT_OFS_STATUS, 32'h10);
    rd_chk(`DDCT_OFS_CMD, 32'h0);
    rd_chk(8'h1C, 32'h0);
  endtask

  // Both inputs at full rate, then counter B gated off alone.
  task automatic t_count;
    u_ddct_far_side.burst(2'b11, 12);
    gate_b <= 1'b0;
    u_ddct_far_side.burst(2'b11, 3);
    gate_b <= 1'b1;
    repeat (4) @(posedge clock);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h15);
    rd_chk(`DDCT_OFS_COUNT_B, 32'h12);
    chk({4'h0, disp_digits}, 32'h15);
    wr_reg(`DDCT_OFS_CTRL, 32'h1C);
    repeat (3) @(posedge clock);
    chk({3'h0, disp_is_b, disp_digits}, 32'h10000012);
  endtask

  // A manual reset while running is ignored; the pin honours the target.
  task automatic t_rtgt;
    wr_reg(`DDCT_OFS_CMD, 32'h4);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h15);
    wr_reg(`DDCT_OFS_CTRL, 32'h4);
    ext_reset <= 1'b1;
    repeat (4) @(posedge clock);
    ext_reset <= 1'b0;
    repeat (5) @(posedge clock);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h0);
    rd_chk(`DDCT_OFS_COUNT_B, 32'h12);
    // As a follower, a preset on the system line halts this unit as well.
    @(posedge clock);
    sys_preset_i <= 1'b1;
    repeat (4) @(posedge clock);
    sys_preset_i <= 1'b0;
    repeat (3) @(posedge clock);
    rd_chk(`DDCT_OFS_STATUS, 32'h1);
    wr_reg(`DDCT_OFS_CMD, 32'h1);
  endtask

  // Single pass as controller: preset 3 x 10 stops both, then refires without a clear.
  task automatic t_single;
    wr_reg(`DDCT_OFS_CTRL, 32'h20C);
    wr_reg(`DDCT_OFS_PRESET, 32'h13);
    u_ddct_far_side.burst(2'b11, 35);
    rd_chk(`DDCT_OFS_STATUS, 32'h1);
    chk({31'h0, sys_gate_oe_n}, 32'h0);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h30);
    rd_chk(`DDCT_OFS_COUNT_B, 32'h42);
    wr_reg(`DDCT_OFS_CMD, 32'h1);
    u_ddct_far_side.burst(2'b01, 100);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h130);
    wr_reg(`DDCT_OFS_CMD, 32'h4);
    rd_chk(`DDCT_OFS_COUNT_B, 32'h0);
    wr_reg(`DDCT_OFS_CMD, 32'h1);
    rd_chk(`DDCT_OFS_STATUS, 32'h10);
  endtask

  // Auto-repeat with the shortest dwell of three tenths, sixty clocks here.
  task automatic t_recycle;
    wr_reg(`DDCT_OFS_DWELL, 32'h3);
    wr_reg(`DDCT_OFS_CTRL, 32'h5);
    wr_reg(`DDCT_OFS_PRESET, 32'h4);
    u_ddct_far_side.burst(2'b01, 4);
    rd_chk(`DDCT_OFS_STATUS, 32'h2);
    repeat (30) @(posedge clock);
    rd_chk(`DDCT_OFS_STATUS, 32'h2);
    repeat (50) @(posedge clock);
    rd_chk(`DDCT_OFS_STATUS, 32'h10);
    rd_chk(`DDCT_OFS_COUNT_A, 32'h0);
  endtask

  // Counter B on the tenth-second base: ten line edges give about five ticks.
  // Self-check mode feeds every rising line edge to counter A, ten or eleven here.
  task automatic t_timer;
    wr_reg(`DDCT_OFS_PRESET, 32'h0);
    wr_reg(`DDCT_OFS_CTRL, 32'hDE);
    repeat (200) @(posedge clock);
    chk({31'h0, disp_digits inside {28'h4, 28'h5, 28'h6}}, 32'h1);
    chk({30'h0, readout_a, readout_b}, 32'h1);
    wr_reg(`DDCT_OFS_CTRL, 32'hAE);
    repeat (3) @(posedge clock);
    chk({31'h0, disp_digits inside {28'h10, 28'h11}}, 32'h1);
    chk({30'h0, readout_a, readout_b}, 32'h2);
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_count;
    t_rtgt;
    t_single;
    t_recycle;
    t_timer;
    complete_run;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      complete_run;
    end
  end
endmodule
`default_nettype wire
